// file: design/bssd_pkg.sv
package bssd_pkg;

   // ----------------------------------------
   // Register indices (byte address = 4 x index)
   // ----------------------------------------
   localparam logic [7:0] IDX_STARTUP_OUT2_STEP = 8'h07;
   localparam logic [7:0] IDX_STARTUP_OUT3 = 8'h08;
   localparam logic [7:0] IDX_STARTUP_OUT4 = 8'h09;
   localparam logic [7:0] IDX_SHUTDOWN_OUT1 = 8'h0A;
   localparam logic [7:0] IDX_SHUTDOWN_OUT2 = 8'h0B;
   localparam logic [7:0] IDX_SOFT_ENABLE = 8'h20;
   localparam logic [7:0] IDX_STATUS = 8'h21;

   // ----------------------------------------
   // Field positions and reset values
   // ----------------------------------------
   localparam int CODE_MSB = 4;
   localparam int UNIT_SEL_BIT = 7;
   localparam logic [7:0] DELAY_REG_RESET = 8'h00;
   localparam logic [7:0] STEP_REG_MASK = 8'h9F;
   localparam logic [7:0] CODE_REG_MASK = 8'h1F;
   localparam logic [7:0] SOFT_EN_MASK = 8'h0F;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ = 40000000;
   localparam int UNIT_MS = 1;
   localparam int UNIT_CYCLES = CLK_HZ / 1000 * UNIT_MS;

   typedef enum logic [1:0] {
      SEQ_OFF = 2'b00,
      SEQ_UP = 2'b01,
      SEQ_ON = 2'b11,
      SEQ_DOWN = 2'b10
   } bssd_state_e;

   typedef struct packed {
      logic [4:0] code;
      logic active;
   } bssd_chan_s;

endpackage

// file: design/bssd_top.sv
// Local design decision: the Avalon-MM register port.
`timescale 1ns/100ps
// Operation
// - One unit-select bit picks a 1 ms (0) or 2 ms (1) step for every delay code.
// - Output 2 power-up delay is timed from the rising edge of the pin enable or global enable function.
// - Each delay is the five-bit code times the unit, zero meaning none and 31 meaning 31 units.
// - The code sits in bits 4:0, code one gives one unit and code two gives two.
// - Output 3 has its own power-up code from the same event, same encoding, reset zero.
// - Output 4 has its own power-up code from the same event, same encoding, reset zero.
// - Power-up delay settings default to zero unless a programmed default overrides them.
// - Output 1 has a five-bit power-down code scaled by the shared unit, up to 31 units.
// - Output 2 has a five-bit power-down code with the same encoding, reset zero meaning immediate.
// - Each output enable is its software bit ORed with an assigned general input's function.
module bssd_top #(
   parameter logic [7:0] OTP_OUT2_STEP = 8'h00,
   parameter logic [7:0] OTP_OUT3 = 8'h00,
   parameter logic [7:0] OTP_OUT4 = 8'h00,
   parameter int UNIT_CYCLES = bssd_pkg::UNIT_CYCLES
) (
   // Clock and reset
   input wire logic mclk_in,
   input wire logic rst_in,
   // Avalon-MM slave
   input wire logic [9:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Enable sources (asynchronous)
   input wire logic en_pin_in,
   input wire logic global_enable_function_in,
   input wire logic [3:0] gpi_out_enable_in,
   // Output enables to regulators
   output logic [3:0] out_enable_out
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   logic glob_prev_reg;

   // First stage, may go metastable
   always_ff @(posedge mclk_in) begin
      sync1_reg <= {gpi_out_enable_in, global_enable_function_in, en_pin_in};
   end

   // Second stage, sole reader of the first
   always_ff @(posedge mclk_in) begin
      sync2_reg <= sync1_reg;
   end

   wire en_pin_sync = sync2_reg[0];
   wire glob_fn_sync = sync2_reg[1];
   wire [3:0] gpi_en_sync = sync2_reg[5:2];
   wire glob_en = en_pin_sync | glob_fn_sync;

   // Previous level, idle low so no false edge after reset
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         glob_prev_reg <= 1'b0;
      end else begin
         glob_prev_reg <= glob_en;
      end
   end

   wire glob_rise = glob_en & ~glob_prev_reg;
   wire glob_fall = ~glob_en & glob_prev_reg;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [7:0] step_out2_reg;
   logic [7:0] out3_on_reg;
   logic [7:0] out4_on_reg;
   logic [7:0] out1_off_reg;
   logic [7:0] out2_off_reg;
   logic [3:0] soft_en_reg;
   logic wait_done_reg;

   // Word index match, shared by write and read decode
   function automatic logic hit(input logic [7:0] index, input logic [7:0] target);
      hit = (index == target);
   endfunction

   wire [7:0] word_index = avs_address_in[9:2];
   wire [7:0] wbyte = avs_writedata_in[7:0];
   // Write lands at the edge where waitrequest is low
   wire wr_stb = avs_write_in & avs_byteenable_in[0] & wait_done_reg;

   // Register selects
   wire sel_step_out2 = hit(word_index, bssd_pkg::IDX_STARTUP_OUT2_STEP);
   wire sel_out3_on = hit(word_index, bssd_pkg::IDX_STARTUP_OUT3);
   wire sel_out4_on = hit(word_index, bssd_pkg::IDX_STARTUP_OUT4);
   wire sel_out1_off = hit(word_index, bssd_pkg::IDX_SHUTDOWN_OUT1);
   wire sel_out2_off = hit(word_index, bssd_pkg::IDX_SHUTDOWN_OUT2);
   wire sel_soft_en = hit(word_index, bssd_pkg::IDX_SOFT_ENABLE);
   wire sel_status = hit(word_index, bssd_pkg::IDX_STATUS);

   // Write strobes
   wire wr_step_out2 = wr_stb & sel_step_out2;
   wire wr_out3_on = wr_stb & sel_out3_on;
   wire wr_out4_on = wr_stb & sel_out4_on;
   wire wr_out1_off = wr_stb & sel_out1_off;
   wire wr_out2_off = wr_stb & sel_out2_off;
   wire wr_soft_en = wr_stb & sel_soft_en;

   // Output 2 power-up code and unit select
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         step_out2_reg <= OTP_OUT2_STEP & bssd_pkg::STEP_REG_MASK;
      end else if (wr_step_out2) begin
         step_out2_reg <= wbyte & bssd_pkg::STEP_REG_MASK;
      end
   end

   // Output 3 power-up code
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         out3_on_reg <= OTP_OUT3 & bssd_pkg::CODE_REG_MASK;
      end else if (wr_out3_on) begin
         out3_on_reg <= wbyte & bssd_pkg::CODE_REG_MASK;
      end
   end

   // Output 4 power-up code
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         out4_on_reg <= OTP_OUT4 & bssd_pkg::CODE_REG_MASK;
      end else if (wr_out4_on) begin
         out4_on_reg <= wbyte & bssd_pkg::CODE_REG_MASK;
      end
   end

   // Output 1 power-down code
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         out1_off_reg <= bssd_pkg::DELAY_REG_RESET;
      end else if (wr_out1_off) begin
         out1_off_reg <= wbyte & bssd_pkg::CODE_REG_MASK;
      end
   end

   // Output 2 power-down code
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         out2_off_reg <= bssd_pkg::DELAY_REG_RESET;
      end else if (wr_out2_off) begin
         out2_off_reg <= wbyte & bssd_pkg::CODE_REG_MASK;
      end
   end

   // Software enable bits
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         soft_en_reg <= 4'h0;
      end else if (wr_soft_en) begin
         soft_en_reg <= wbyte[3:0];
      end
   end

   // One wait cycle per access, answered on the second edge
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         wait_done_reg <= 1'b0;
      end else begin
         wait_done_reg <= (avs_read_in | avs_write_in) & ~wait_done_reg;
      end
   end
   assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~wait_done_reg;

   // ----------------------------------------
   // Delay codes and unit
   // ----------------------------------------
   wire unit_double = step_out2_reg[bssd_pkg::UNIT_SEL_BIT];
   wire [4:0] out2_on_delay_code = step_out2_reg[bssd_pkg::CODE_MSB:0];
   wire [4:0] out3_on_delay_code = out3_on_reg[bssd_pkg::CODE_MSB:0];
   wire [4:0] out4_on_delay_code = out4_on_reg[bssd_pkg::CODE_MSB:0];
   wire [4:0] out1_off_delay_code = out1_off_reg[bssd_pkg::CODE_MSB:0];
   wire [4:0] out2_off_delay_code = out2_off_reg[bssd_pkg::CODE_MSB:0];
   // Output 1 powers up with no delay, outputs 3 and 4 power down with none
   wire [4:0] on_code [4];
   wire [4:0] off_code [4];
   assign on_code[0] = 5'h00;
   assign on_code[1] = out2_on_delay_code;
   assign on_code[2] = out3_on_delay_code;
   assign on_code[3] = out4_on_delay_code;
   assign off_code[0] = out1_off_delay_code;
   assign off_code[1] = out2_off_delay_code;
   assign off_code[2] = 5'h00;
   assign off_code[3] = 5'h00;

   // Units to wait: code, or twice code for the 2 ms step
   function automatic logic [5:0] units_of(input logic [4:0] code, input logic dbl);
      if (dbl) begin
         units_of = {code, 1'b0};
      end else begin
         units_of = {1'b0, code};
      end
   endfunction

   // ----------------------------------------
   // Shared unit tick
   // ----------------------------------------
   logic [31:0] tick_cnt_reg;
   wire unit_tick = (tick_cnt_reg == 32'(UNIT_CYCLES - 1));
   always_ff @(posedge mclk_in) begin
      if (rst_in | glob_rise | glob_fall | unit_tick) begin
         tick_cnt_reg <= 32'h00000000;
      end else begin
         tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      end
   end

   // ----------------------------------------
   // Per-output sequencers
   // ----------------------------------------
   bssd_pkg::bssd_state_e state_reg [4];
   logic [5:0] units_reg [4];
   logic [3:0] seq_on;
   logic [3:0] eff_en;

   for (genvar i = 0; i < 4; i++) begin : g_out
      wire [5:0] up_units = units_of(on_code[i], unit_double);
      wire [5:0] down_units = units_of(off_code[i], unit_double);
      wire count_done = (units_reg[i] == 6'h00);
      bssd_pkg::bssd_state_e state_next;
      logic [5:0] units_next;

      // An enable edge restarts the count from the new edge
      always_comb begin
         state_next = state_reg[i];
         units_next = units_reg[i];
         if (glob_rise) begin
            state_next = bssd_pkg::SEQ_UP;
            units_next = up_units;
         end else if (glob_fall) begin
            state_next = bssd_pkg::SEQ_DOWN;
            units_next = down_units;
         end else begin
            case (state_reg[i])
               bssd_pkg::SEQ_UP: begin
                  if (count_done) begin
                     state_next = bssd_pkg::SEQ_ON;
                  end else if (unit_tick) begin
                     units_next = units_reg[i] - 6'h01;
                  end
               end
               bssd_pkg::SEQ_DOWN: begin
                  if (count_done) begin
                     state_next = bssd_pkg::SEQ_OFF;
                  end else if (unit_tick) begin
                     units_next = units_reg[i] - 6'h01;
                  end
               end
               bssd_pkg::SEQ_ON: state_next = bssd_pkg::SEQ_ON;
               bssd_pkg::SEQ_OFF: state_next = bssd_pkg::SEQ_OFF;
               default: state_next = bssd_pkg::SEQ_OFF;
            endcase
         end
      end

      always_ff @(posedge mclk_in) begin
         if (rst_in) begin
            state_reg[i] <= bssd_pkg::SEQ_OFF;
            units_reg[i] <= 6'h00;
         end else begin
            state_reg[i] <= state_next;
            units_reg[i] <= units_next;
         end
      end

      // Output held on until its power-down count runs out
      assign seq_on[i] = (state_reg[i] == bssd_pkg::SEQ_ON) ||
                         (state_reg[i] == bssd_pkg::SEQ_DOWN);
      assign eff_en[i] = seq_on[i] | soft_en_reg[i] | gpi_en_sync[i];
   end

   logic [3:0] out_en_reg;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         out_en_reg <= 4'h0;
      end else begin
         out_en_reg <= eff_en;
      end
   end

   assign out_enable_out = out_en_reg;

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   wire [7:0] soft_byte = {4'h0, soft_en_reg};
   wire [7:0] status_byte = {3'h0, glob_en, out_en_reg};
   // Captured in the wait cycle, stands when waitrequest drops
   wire rd_stb = avs_read_in & ~wait_done_reg;

   // Unmapped indices select nothing and read zero
   logic [7:0] rd_byte;
   assign rd_byte = ({8{sel_step_out2}} & step_out2_reg) |
                    ({8{sel_out3_on}} & out3_on_reg) |
                    ({8{sel_out4_on}} & out4_on_reg) |
                    ({8{sel_out1_off}} & out1_off_reg) |
                    ({8{sel_out2_off}} & out2_off_reg) |
                    ({8{sel_soft_en}} & soft_byte) |
                    ({8{sel_status}} & status_byte);

   logic [31:0] rdata_reg;

   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         rdata_reg <= 32'h00000000;
      end else if (rd_stb) begin
         rdata_reg <= {24'h000000, rd_byte};
      end
   end

   assign avs_readdata_out = rdata_reg;

endmodule

// file: verif/bssd_props.sv
`timescale 1ns/100ps
module bssd_props #(
   parameter int UNIT_CYCLES = 10
) (
   // Clock, reset, bus
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic [9:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   // Enables
   input wire logic en_pin_in,
   input wire logic global_enable_function_in,
   input wire logic [3:0] gpi_out_enable_in,
   input wire logic [3:0] out_enable_out
);
   logic [3:0] soft_reg;
   wire [7:0] idx = avs_address_in[9:2];
   wire soft_wr = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0] && idx == bssd_pkg::IDX_SOFT_ENABLE;
   wire idle = !en_pin_in && !global_enable_function_in && gpi_out_enable_in[3:2] == 2'b00 && soft_reg[3:2] == 2'b00;
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         soft_reg <= 4'h0;
      end else if (soft_wr) begin
         soft_reg <= avs_writedata_in[3:0];
      end
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   sequence req_wait; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
   sequence rd_done; avs_read_in && !avs_waitrequest_out; endsequence
   wait_first_a:
      assert property ($rose(avs_read_in || avs_write_in) |-> avs_waitrequest_out) else $error("no wait cycle");
   wait_one_a:
      assert property (req_wait |=> !avs_waitrequest_out) else $error("wait too long");
   step_resv_a:
      assert property (rd_done ##0 idx == 8'h07 |-> (avs_readdata_out & 32'hFFFFFF60) == 32'h0) else $error("bits set");
   code_resv_a:
      assert property (rd_done ##0 (idx > 8'h07 && idx < 8'h0C) |-> (avs_readdata_out & 32'hFFFFFFE0) == 32'h0)
      else $error("bits set");
   data_hold_a:
      assert property ((!avs_read_in)[*2] |=> $stable(avs_readdata_out)) else $error("readdata moved");
   gpi_or_a:
      assert property (gpi_out_enable_in[3] [*6] |-> out_enable_out[3]) else $error("gpi not ORed");
   soft_or_a:
      assert property (soft_reg[0] [*4] |-> out_enable_out[0]) else $error("soft bit not ORed");
   fast_off_a:
      assert property (idle [*8] |-> out_enable_out[3:2] == 2'b00) else $error("late shutdown");
endmodule
bind bssd_top bssd_props #(.UNIT_CYCLES(UNIT_CYCLES)) i_bssd_props (.*);

// file: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
   localparam int UC = 10;
   logic mclk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [9:0] avs_address_in = 10'h000;
   logic avs_read_in = 1'b0;
   logic avs_write_in = 1'b0;
   logic [31:0] avs_writedata_in = 32'h0;
   logic [3:0] avs_byteenable_in = 4'hF;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic en_pin_in = 1'b0;
   logic global_enable_function_in = 1'b0;
   logic [3:0] gpi_out_enable_in = 4'h0;
   logic [3:0] out_enable_out;
   logic [3:0] prev_en = 4'h0;
   logic [7:0] shadow [7:12];
   logic [7:0] cfg [5] = '{8'h63, 8'hE1, 8'hA5, 8'h42, 8'hE4};
   logic [31:0] rd_q[$];
   logic [35:0] ev_q[$];
   int failures = 0;
   int n_compared = 0;
   int cyc = 0;
   int t0 = 0;
   int u;
   bssd_top #(.UNIT_CYCLES(UC)) i_bssd_top (.*);
   initial begin
      forever #12.5 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) cyc <= cyc + 1;
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic acc(logic wr, logic [7:0] idx, logic [7:0] d, logic [3:0] be);
      @(posedge mclk_in);
      avs_read_in <= !wr;
      avs_write_in <= wr;
      avs_address_in <= {idx, 2'b00};
      avs_writedata_in <= {24'h0, d};
      avs_byteenable_in <= be;
      do begin
         @(posedge mclk_in);
      end while (avs_waitrequest_out !== 1'b0);
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
   endtask
   task automatic rd(int i, logic [7:0] exp);
      rd_q.push_back({24'h0, exp});
      acc(1'b0, 8'(i), 8'h00, 4'hF);
   endtask
   task automatic drain();
      int n;
      n = 0;
      while (ev_q.size() > 0 && n < 3000) begin
         @(posedge mclk_in);
         n++;
      end
      check("pending", ev_q.size(), 0);
   endtask
   // ----------------------------------------
   // Result monitor
   // ----------------------------------------
   always @(posedge mclk_in) begin
      if (avs_read_in && avs_waitrequest_out === 1'b0) begin
         check("readdata", avs_readdata_out, rd_q.size() ? rd_q.pop_front() : 32'hX);
      end
   end
   always @(negedge mclk_in) begin
      logic [35:0] e;
      int d;
      if (!rst_in && out_enable_out !== prev_en) begin
         e = ev_q.size() ? ev_q.pop_front() : 36'hX;
         d = cyc - t0;
         check("out_enable", out_enable_out, e[35:32]);
         check("delay", (d >= e[31:0] && d <= e[31:0] + 8) ? e[31:0] : 32'(d), e[31:0]);
         prev_en = out_enable_out;
      end
   end
   initial begin
      #(25 * 30000);
      check("watchdog", 0, 1);
      give_verdict();
   end
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      void'($urandom(27));
      repeat (6) @(posedge mclk_in);
      rst_in <= 1'b0;
      for (int i = 7; i <= 12; i++) begin
         shadow[i] = 8'($urandom);
         rd(i, 8'h00);
         acc(1'b1, 8'(i), shadow[i], 4'h1);
         rd(i, shadow[i] & (i == 7 ? 8'h9F : (i == 12 ? 8'h00 : 8'h1F)));
      end
      acc(1'b1, 8'h08, ~shadow[8], 4'h0);
      rd(8, shadow[8] & 8'h1F);
      $display("test registers done");
      for (int s = 0; s < 2; s++) begin
         u = (s + 1) * UC;
         for (int j = 0; j < 5; j++) acc(1'b1, 8'(7 + j), cfg[j] | (j == 0 ? {s[0], 7'h00} : 8'h00), 4'h1);
         @(posedge mclk_in);
         t0 = cyc;
         ev_q = '{{4'h1, 32'd0}, {4'h5, 32'(u)}, {4'h7, 32'(3 * u)}, {4'hF, 32'(5 * u)}};
         if (s == 1) global_enable_function_in <= 1'b1;
         else en_pin_in <= 1'b1;
         drain();
         @(posedge mclk_in);
         t0 = cyc;
         ev_q = '{{4'h3, 32'd0}, {4'h2, 32'(2 * u)}, {4'h0, 32'(4 * u)}};
         en_pin_in <= 1'b0;
         global_enable_function_in <= 1'b0;
         drain();
      end
      $display("test sequencing done");
      for (int k = 0; k < 2; k++) begin
         @(posedge mclk_in);
         t0 = cyc;
         ev_q = '{{k ? 4'h1 : 4'h8, 32'd0}};
         gpi_out_enable_in <= k ? 4'h0 : 4'h8;
         drain();
         t0 = cyc;
         ev_q = '{{k ? 4'h0 : 4'h9, 32'd0}};
         acc(1'b1, 8'h20, k ? 8'h00 : 8'h01, 4'h1);
         drain();
      end
      $display("test enables done");
      give_verdict();
   end
endmodule
